//--- shared/lds_pkg.sv
// Constants, a carrier struct and state encodings for the DMA command sequencer
// Summary of operation
// - Command register write sets busy and sends a host-to-device register frame.
// - DMA holds software address pointer and direction, armed by a run flag.
// - Inbound Data frame with programmed DMA goes to memory at the pointer.
// - Ending register frame loads status; interrupt only when its flag bit is set.
// - Ending register frame with no prior Data frame on a read is accepted.
// - Armed write DMA stays paused and sends nothing until the device activates it.
// - Activate frame starts the armed DMA, which sends write data as a Data frame.
// - Total write data sent is limited by the programmed transfer count.
// - Ending register frame on a write with no Activate frame is accepted.
package lds_pkg;
  // Frame type codes
  localparam logic [7:0] FIS_H2D = 8'h27;
  localparam logic [7:0] FIS_D2H = 8'h34;
  localparam logic [7:0] FIS_ACT = 8'h39;
  localparam logic [7:0] FIS_DATA = 8'h46;
  localparam logic [7:0] H2D_CBIT = 8'h80;
  localparam int D2H_IBIT = 14;
  localparam int BSY_BIT = 7;
  localparam logic [2:0] H2D_LAST = 3'h4;
  localparam int DW_BYTES = 4;
  // Register byte offsets
  localparam logic [7:0] OFF_FEAT = 8'h00;
  localparam logic [7:0] OFF_LBA = 8'h04;
  localparam logic [7:0] OFF_LBA_EXP = 8'h08;
  localparam logic [7:0] OFF_COUNT = 8'h0c;
  localparam logic [7:0] OFF_CMD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_DMA_ADDR = 8'h18;
  localparam logic [7:0] OFF_DMA_LEN = 8'h1c;
  localparam logic [7:0] OFF_DMA_CTRL = 8'h20;
  localparam logic [7:0] OFF_DMA_STAT = 8'h24;
  localparam int CTRL_RUN = 0;
  localparam int CTRL_DIR = 1;
  localparam logic [7:0] STATUS_RST = 8'h00;
  // One dword on the link with frame delimiters
  typedef struct packed {
    logic sof;
    logic eof;
    logic [31:0] data;
  } lds_word_t;
  typedef enum logic [1:0] {
    DMA_IDLE = 2'b00,
    DMA_ARMED = 2'b01,
    DMA_ACTIVE = 2'b10
  } lds_dma_st_t;
  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_REG = 2'b01,
    RX_DATA = 2'b10,
    RX_DROP = 2'b11
  } lds_rx_st_t;
  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_CMD = 3'b001,
    TX_DHDR = 3'b010,
    TX_DREAD = 3'b011,
    TX_DPUSH = 3'b100
  } lds_tx_st_t;
endpackage

//--- design/lds_sequencer.sv
// Host adapter command sequencer with legacy DMA engine and APB registers
module lds_sequencer #(
  parameter int AW = 32,
  parameter int CNT_W = 16,
  parameter int MAX_FIS_DW = 2048
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire lds_pkg::lds_word_t rx_word,
  input wire logic rx_valid,
  output logic rx_ready,
  output lds_pkg::lds_word_t tx_word,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic mem_req,
  output logic mem_we,
  output logic [AW-1:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  output logic host_intr
);
  logic pready_reg, pslverr_reg, rx_ready_reg, intr_reg;
  logic [31:0] prdata_reg, rd_mux;
  logic rd_mapped;
  logic [15:0] feat_reg;
  logic [31:0] lba_reg, lba_exp_reg, count_reg;
  logic [7:0] cmd_reg, status_reg, error_reg;
  logic [7:0] tmp_status_reg, tmp_error_reg;
  logic tmp_intr_reg;
  logic [1:0] rx_idx_reg;
  lds_pkg::lds_rx_st_t rx_st_reg;
  lds_pkg::lds_tx_st_t tx_st_reg;
  lds_pkg::lds_dma_st_t dma_st_reg;
  logic dir_reg, cmd_pend_reg, act_pend_reg;
  logic [AW-1:0] addr_reg;
  logic [CNT_W-1:0] left_reg, fis_left_reg;
  logic [2:0] tx_idx_reg;
  logic [31:0] hold_reg;
  logic mem_req_reg, mem_we_reg;
  logic [31:0] mem_wdata_reg;
  lds_pkg::lds_word_t e0_reg, e1_reg, e0_next, e1_next, push_word;
  logic v0_reg, v1_reg, v0_next, v1_next, push, pop, buf_in_ready;
  logic apb_acc, wr_en, rd_en, cmd_wr, ctrl_wr;
  logic rx_acc, rx_to_mem, d2h_commit, mem_done;
  logic [7:0] rx_type;

  // Bus and link qualifiers
  assign apb_acc = psel && penable && pready_reg;
  assign wr_en = apb_acc && pwrite;
  assign rd_en = apb_acc && !pwrite;
  assign cmd_wr = wr_en && (paddr == lds_pkg::OFF_CMD);
  assign ctrl_wr = wr_en && (paddr == lds_pkg::OFF_DMA_CTRL);
  assign rx_acc = rx_valid && rx_ready_reg;
  assign rx_type = rx_word.data[7:0];
  assign d2h_commit = rx_acc && rx_word.eof && (rx_st_reg == lds_pkg::RX_REG);
  assign rx_to_mem = rx_acc && (rx_st_reg == lds_pkg::RX_DATA) &&
                     (left_reg != '0);
  assign mem_done = mem_req_reg && mem_ack;

  // Read multiplexer; unmapped offsets read zero with an error
  always_comb begin
    rd_mapped = 1'b1;
    case (paddr)
      lds_pkg::OFF_FEAT: rd_mux = {16'h0000, feat_reg};
      lds_pkg::OFF_LBA: rd_mux = lba_reg;
      lds_pkg::OFF_LBA_EXP: rd_mux = lba_exp_reg;
      lds_pkg::OFF_COUNT: rd_mux = count_reg;
      lds_pkg::OFF_CMD: rd_mux = {24'h000000, cmd_reg};
      lds_pkg::OFF_STATUS: rd_mux = {16'h0000, error_reg, status_reg};
      lds_pkg::OFF_DMA_ADDR: rd_mux = 32'(addr_reg);
      lds_pkg::OFF_DMA_LEN: rd_mux = 32'(left_reg);
      lds_pkg::OFF_DMA_CTRL:
        rd_mux = {30'h0, dir_reg, dma_st_reg != lds_pkg::DMA_IDLE};
      lds_pkg::OFF_DMA_STAT: rd_mux = {30'h0, dma_st_reg};
      default: begin
        rd_mux = 32'h00000000;
        rd_mapped = 1'b0;
      end
    endcase
  end

  // APB answer: one wait state, so every output comes from a flop
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pready_reg <= 1'b0;
      prdata_reg <= 32'h00000000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg <= psel && penable && !pready_reg;
      if (psel && penable && !pready_reg) begin
        prdata_reg <= pwrite ? 32'h00000000 : rd_mux;
        pslverr_reg <= !rd_mapped;
      end else begin
        pslverr_reg <= 1'b0;
      end
    end
  end

  // Shadow register block; busy set by a command write beats a frame load
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      feat_reg <= 16'h0000;
      lba_reg <= 32'h00000000;
      lba_exp_reg <= 32'h00000000;
      count_reg <= 32'h00000000;
      cmd_reg <= 8'h00;
      status_reg <= lds_pkg::STATUS_RST;
      error_reg <= 8'h00;
    end else begin
      if (wr_en) begin
        case (paddr)
          lds_pkg::OFF_FEAT: feat_reg <= pwdata[15:0];
          lds_pkg::OFF_LBA: lba_reg <= pwdata;
          lds_pkg::OFF_LBA_EXP: lba_exp_reg <= pwdata;
          lds_pkg::OFF_COUNT: count_reg <= pwdata;
          lds_pkg::OFF_CMD: cmd_reg <= pwdata[7:0];
          default: ;
        endcase
      end
      if (rx_acc && (rx_st_reg == lds_pkg::RX_REG)) begin
        case (rx_idx_reg)
          2'h0: lba_reg <= rx_word.data;
          2'h1: lba_exp_reg <= rx_word.data;
          2'h2: count_reg[15:0] <= rx_word.data[15:0];
          default: ;
        endcase
      end
      if (d2h_commit) begin
        status_reg <= tmp_status_reg;
        error_reg <= tmp_error_reg;
      end
      if (cmd_wr)
        status_reg[lds_pkg::BSY_BIT] <= 1'b1;
    end
  end

  // Host interrupt: raised by a flagged ending frame, dropped by status read
  always_ff @(posedge sys_clk) begin
    if (rst)
      intr_reg <= 1'b0;
    else if (d2h_commit && tmp_intr_reg)
      intr_reg <= 1'b1;
    else if (rd_en && (paddr == lds_pkg::OFF_STATUS))
      intr_reg <= 1'b0;
  end

  // Inbound frame parser; register frames are taken in any DMA state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rx_st_reg <= lds_pkg::RX_IDLE;
      rx_idx_reg <= 2'h0;
      tmp_status_reg <= 8'h00;
      tmp_error_reg <= 8'h00;
      tmp_intr_reg <= 1'b0;
    end else begin
      case (rx_st_reg)
        lds_pkg::RX_IDLE: begin
          if (rx_acc && rx_word.sof && !rx_word.eof) begin
            rx_idx_reg <= 2'h0;
            if (rx_type == lds_pkg::FIS_D2H) begin
              rx_st_reg <= lds_pkg::RX_REG;
              tmp_status_reg <= rx_word.data[23:16];
              tmp_error_reg <= rx_word.data[31:24];
              tmp_intr_reg <= rx_word.data[lds_pkg::D2H_IBIT];
            end else if (rx_type == lds_pkg::FIS_DATA && dir_reg &&
                         dma_st_reg != lds_pkg::DMA_IDLE) begin
              rx_st_reg <= lds_pkg::RX_DATA;
            end else begin
              rx_st_reg <= lds_pkg::RX_DROP;
            end
          end
        end
        lds_pkg::RX_REG: begin
          if (rx_acc) begin
            rx_idx_reg <= rx_idx_reg + 2'h1;
            if (rx_word.eof)
              rx_st_reg <= lds_pkg::RX_IDLE;
          end
        end
        lds_pkg::RX_DATA, lds_pkg::RX_DROP: begin
          if (rx_acc && rx_word.eof)
            rx_st_reg <= lds_pkg::RX_IDLE;
        end
        default: rx_st_reg <= lds_pkg::RX_IDLE;
      endcase
    end
  end

  // Inbound flow control: hold the link while a data word is in memory
  always_ff @(posedge sys_clk) begin
    if (rst)
      rx_ready_reg <= 1'b1;
    else if (rx_to_mem)
      rx_ready_reg <= 1'b0;
    else if (mem_done)
      rx_ready_reg <= 1'b1;
  end

  // Memory port; one request outstanding, shared by both directions
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mem_req_reg <= 1'b0;
      mem_we_reg <= 1'b0;
      mem_wdata_reg <= 32'h00000000;
    end else if (mem_done) begin
      mem_req_reg <= 1'b0;
    end else if (rx_to_mem) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b1;
      mem_wdata_reg <= rx_word.data;
    end else if (tx_st_reg == lds_pkg::TX_DREAD && !mem_req_reg) begin
      mem_req_reg <= 1'b1;
      mem_we_reg <= 1'b0;
    end
  end

  // DMA engine: pointer, remaining count, direction and run state
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dma_st_reg <= lds_pkg::DMA_IDLE;
      dir_reg <= 1'b0;
      addr_reg <= '0;
      left_reg <= '0;
    end else begin
      if (wr_en && paddr == lds_pkg::OFF_DMA_ADDR)
        addr_reg <= AW'(pwdata);
      if (wr_en && paddr == lds_pkg::OFF_DMA_LEN)
        left_reg <= pwdata[CNT_W-1:0];
      if (ctrl_wr) begin
        // Clearing run is the software abort after an early ending status
        dir_reg <= pwdata[lds_pkg::CTRL_DIR];
        dma_st_reg <= pwdata[lds_pkg::CTRL_RUN] ? lds_pkg::DMA_ARMED :
                      lds_pkg::DMA_IDLE;
      end else begin
        if (mem_done) begin
          addr_reg <= addr_reg + AW'(lds_pkg::DW_BYTES);
          left_reg <= left_reg - CNT_W'(1);
          if (dir_reg && left_reg == CNT_W'(1))
            dma_st_reg <= lds_pkg::DMA_IDLE;
        end
        if (rx_st_reg == lds_pkg::RX_DATA && rx_to_mem &&
            dma_st_reg == lds_pkg::DMA_ARMED)
          dma_st_reg <= lds_pkg::DMA_ACTIVE;
        if (tx_st_reg == lds_pkg::TX_IDLE && !cmd_pend_reg && act_pend_reg)
          dma_st_reg <= lds_pkg::DMA_ACTIVE;
        if (tx_st_reg == lds_pkg::TX_DPUSH && push &&
            fis_left_reg == CNT_W'(1))
          dma_st_reg <= (left_reg == '0) ? lds_pkg::DMA_IDLE :
                        lds_pkg::DMA_ARMED;
      end
    end
  end

  // Pending command and activation; a new event wins over its clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cmd_pend_reg <= 1'b0;
      act_pend_reg <= 1'b0;
    end else begin
      if (tx_st_reg == lds_pkg::TX_IDLE)
        cmd_pend_reg <= 1'b0;
      if (cmd_wr)
        cmd_pend_reg <= 1'b1;
      if (tx_st_reg == lds_pkg::TX_IDLE && !cmd_pend_reg)
        act_pend_reg <= 1'b0;
      if (rx_acc && rx_word.sof && rx_st_reg == lds_pkg::RX_IDLE &&
          rx_type == lds_pkg::FIS_ACT && !dir_reg && left_reg != '0 &&
          dma_st_reg == lds_pkg::DMA_ARMED)
        act_pend_reg <= 1'b1;
    end
  end

  // Outbound word generator feeding the two-entry buffer
  always_comb begin
    push = 1'b0;
    push_word = '0;
    case (tx_st_reg)
      lds_pkg::TX_CMD: begin
        push = buf_in_ready;
        push_word.sof = (tx_idx_reg == 3'h0);
        push_word.eof = (tx_idx_reg == lds_pkg::H2D_LAST);
        case (tx_idx_reg)
          3'h0: push_word.data = {feat_reg[7:0], cmd_reg,
                                  lds_pkg::H2D_CBIT, lds_pkg::FIS_H2D};
          3'h1: push_word.data = lba_reg;
          3'h2: push_word.data = {feat_reg[15:8], lba_exp_reg[23:0]};
          3'h3: push_word.data = count_reg;
          default: push_word.data = 32'h00000000;
        endcase
      end
      lds_pkg::TX_DHDR: begin
        push = buf_in_ready;
        push_word.sof = 1'b1;
        push_word.data = {24'h000000, lds_pkg::FIS_DATA};
      end
      lds_pkg::TX_DPUSH: begin
        push = buf_in_ready;
        push_word.eof = (fis_left_reg == CNT_W'(1));
        push_word.data = hold_reg;
      end
      default: ;
    endcase
  end

  // Outbound sequencer; a pending command goes before write data
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tx_st_reg <= lds_pkg::TX_IDLE;
      tx_idx_reg <= 3'h0;
      fis_left_reg <= '0;
      hold_reg <= 32'h00000000;
    end else begin
      case (tx_st_reg)
        lds_pkg::TX_IDLE: begin
          tx_idx_reg <= 3'h0;
          if (cmd_pend_reg) begin
            tx_st_reg <= lds_pkg::TX_CMD;
          end else if (act_pend_reg) begin
            tx_st_reg <= lds_pkg::TX_DHDR;
            // One frame per activation, never past the programmed count
            fis_left_reg <= (left_reg > CNT_W'(MAX_FIS_DW)) ?
                            CNT_W'(MAX_FIS_DW) : left_reg;
          end
        end
        lds_pkg::TX_CMD: begin
          if (push) begin
            tx_idx_reg <= tx_idx_reg + 3'h1;
            if (tx_idx_reg == lds_pkg::H2D_LAST)
              tx_st_reg <= lds_pkg::TX_IDLE;
          end
        end
        lds_pkg::TX_DHDR: begin
          if (push)
            tx_st_reg <= lds_pkg::TX_DREAD;
        end
        lds_pkg::TX_DREAD: begin
          if (mem_done) begin
            hold_reg <= mem_rdata;
            tx_st_reg <= lds_pkg::TX_DPUSH;
          end
        end
        lds_pkg::TX_DPUSH: begin
          if (push) begin
            fis_left_reg <= fis_left_reg - CNT_W'(1);
            tx_st_reg <= (fis_left_reg == CNT_W'(1)) ? lds_pkg::TX_IDLE :
                         lds_pkg::TX_DREAD;
          end
        end
        default: tx_st_reg <= lds_pkg::TX_IDLE;
      endcase
    end
  end

  // Two-entry buffer; entry 0 drives the link, so a stall loses no word
  assign pop = v0_reg && tx_ready;
  assign buf_in_ready = !v1_reg;
  always_comb begin
    e0_next = pop ? e1_reg : e0_reg;
    v0_next = pop ? v1_reg : v0_reg;
    e1_next = e1_reg;
    v1_next = pop ? 1'b0 : v1_reg;
    if (push) begin
      if (!v0_next) begin
        e0_next = push_word;
        v0_next = 1'b1;
      end else begin
        e1_next = push_word;
        v1_next = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      e0_reg <= '0;
      e1_reg <= '0;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else begin
      e0_reg <= e0_next;
      e1_reg <= e1_next;
      v0_reg <= v0_next;
      v1_reg <= v1_next;
    end
  end

  // Port drivers, all straight from flops
  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign rx_ready = rx_ready_reg;
  assign tx_word = e0_reg;
  assign tx_valid = v0_reg;
  assign mem_req = mem_req_reg;
  assign mem_we = mem_we_reg;
  assign mem_addr = addr_reg;
  assign mem_wdata = mem_wdata_reg;
  assign host_intr = intr_reg;

  // Checks on the sequencing
  busy_on_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
    cmd_wr |=> status_reg[lds_pkg::BSY_BIT] && cmd_pend_reg)
    else $error("busy not set after command write");
  cmd_frame_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_st_reg == lds_pkg::TX_CMD && tx_idx_reg == 3'h0 && push |=>
    v0_reg && (v1_reg ? e1_reg.data[7:0] : e0_reg.data[7:0])
    == lds_pkg::FIS_H2D)
    else $error("command frame header not buffered");
  run_arms_a: assert property (@(posedge sys_clk) disable iff (rst)
    ctrl_wr && pwdata[lds_pkg::CTRL_RUN] |=>
    dma_st_reg == lds_pkg::DMA_ARMED)
    else $error("run flag did not arm the engine");
  route_mem_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_to_mem |=> mem_req_reg && mem_we_reg && !rx_ready_reg &&
    mem_wdata_reg == $past(rx_word.data))
    else $error("data word not routed to memory");
  intr_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
    d2h_commit |=> (host_intr == ($past(tmp_intr_reg) || $past(intr_reg)))
    && status_reg[lds_pkg::BSY_BIT] == ($past(tmp_status_reg[7]) ||
    $past(cmd_wr)))
    else $error("ending status or interrupt wrong");
  // Only a data word still in flight to memory may hold off a new frame
  reg_taken_a: assert property (@(posedge sys_clk) disable iff (rst)
    rx_st_reg == lds_pkg::RX_IDLE && !(mem_req_reg && mem_we_reg) |->
    rx_ready_reg)
    else $error("idle parser refused a frame");
  write_paused_a: assert property (@(posedge sys_clk) disable iff (rst)
    dma_st_reg != lds_pkg::DMA_ACTIVE |-> tx_st_reg != lds_pkg::TX_DREAD &&
    tx_st_reg != lds_pkg::TX_DPUSH)
    else $error("write data moved while not activated");
  act_starts_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_st_reg == lds_pkg::TX_IDLE && act_pend_reg && !cmd_pend_reg |=>
    tx_st_reg == lds_pkg::TX_DHDR ##1 tx_st_reg != lds_pkg::TX_IDLE)
    else $error("activation did not start a data frame");
  count_bound_a: assert property (@(posedge sys_clk) disable iff (rst)
    tx_st_reg == lds_pkg::TX_DPUSH |-> fis_left_reg != '0 &&
    $past(left_reg) >= left_reg)
    else $error("write data beyond the programmed count");
endmodule

//--- tb/lds_dev_model.sv
// Storage device side of the frame link, fed with frames by the bench
module lds_dev_model (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic slow,
  output lds_pkg::lds_word_t rx_word,
  output logic rx_valid,
  input wire logic rx_ready,
  input wire lds_pkg::lds_word_t tx_word,
  input wire logic tx_valid,
  output logic tx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  lds_pkg::lds_word_t out_q[$];
  lds_pkg::lds_word_t got_q[$];
  // Queue one word for the adapter
  task automatic send(input logic s, input logic e, input logic [31:0] d);
    out_q.push_back({s, e, d});
  endtask
  // A word is held until the adapter takes it; idle data keeps toggling
  always @(posedge sys_clk) begin
    if (rst) begin
      rx_valid <= 1'b0;
      rx_word <= '0;
      tx_ready <= 1'b0;
    end else begin
      if (tx_valid && tx_ready) got_q.push_back(tx_word);
      tx_ready <= slow ? ~tx_ready : 1'b1;  // Stall half the cycles
      if (rx_valid && rx_ready) void'(out_q.pop_front());
      if (out_q.size() > 0) begin
        rx_valid <= 1'b1;
        rx_word <= out_q[0];
      end else begin
        rx_valid <= 1'b0;
        rx_word <= ~rx_word;  // Stale value can look like a frame start; rx_valid stays low
      end
    end
  end
endmodule

//--- tb/test_lds_sequencer.sv
// Self-checking bench for the DMA command sequencer
module test_lds_sequencer;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, mem_addr, mem_wdata, q;
  logic [31:0] mem_rdata = 32'h0;
  logic pready, pslverr, rx_valid, rx_ready, tx_valid, tx_ready, err;
  logic mem_req, mem_we, host_intr;
  logic mem_ack = 1'b0;
  logic slow = 1'b0;
  lds_pkg::lds_word_t rx_word, tx_word;
  logic [31:0] mem_w[logic [31:0]];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  lds_sequencer #(.MAX_FIS_DW(4)) u_lds_sequencer (
    .sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_ack(mem_ack), .mem_rdata(mem_rdata), .host_intr(host_intr));
  lds_dev_model u_lds_dev_model (
    .sys_clk(sys_clk), .rst(rst), .slow(slow), .rx_word(rx_word),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .tx_word(tx_word),
    .tx_valid(tx_valid), .tx_ready(tx_ready));
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // Memory acks a cycle after each request; reads return a tagged address
  always @(posedge sys_clk) begin
    mem_ack <= mem_req && !mem_ack;
    mem_rdata <= {16'hda7a, mem_addr[15:0]};
    if (mem_req && mem_ack && mem_we) mem_w[mem_addr] = mem_wdata;
    cycles++;
    if (cycles > 20000) begin
      fails++;
      stop_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: %s", $time, m);
      fails++;
    end
  endtask
  // One APB transfer; held until pready is seen high at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Wait for sent words and a drained inbound queue; the timeout bounds it
  task automatic wait_idle(input int n);
    while (u_lds_dev_model.got_q.size() < n ||
           u_lds_dev_model.out_q.size() > 0) begin
      @(posedge sys_clk);
    end
    repeat (6) @(posedge sys_clk);
  endtask
  task automatic chw(input int i, input logic [1:0] se,
                     input logic [31:0] d);
    lds_pkg::lds_word_t w;
    w = u_lds_dev_model.got_q[i];
    chk({30'h0, w.sof, w.eof}, {30'h0, se}, "frame delimiters");
    chk(w.data, d, "frame word");
  endtask
  // Shadow registers first, command last; the frame must mirror them
  task automatic issue(input logic [7:0] cmd);
    int b;
    b = u_lds_dev_model.got_q.size();
    apb(1'b1, lds_pkg::OFF_FEAT, 32'h0000ab12);
    apb(1'b1, lds_pkg::OFF_LBA, 32'he0123456);
    apb(1'b1, lds_pkg::OFF_LBA_EXP, 32'h00000789);
    apb(1'b1, lds_pkg::OFF_COUNT, 32'h00000003);
    apb(1'b1, lds_pkg::OFF_CMD, {24'h0, cmd});
    apb(1'b0, lds_pkg::OFF_STATUS, 32'h0);
    chk({31'h0, q[7]}, 32'h1, "busy after command");
    wait_idle(b + 5);
    chw(b, 2'b10, {8'h12, cmd, 8'h80, 8'h27});
    chw(b + 1, 2'b00, 32'he0123456);
    chw(b + 2, 2'b00, 32'hab000789);
    chw(b + 3, 2'b00, 32'h00000003);
    chw(b + 4, 2'b01, 32'h0);
  endtask
  // Five-word ending register frame from the device
  task automatic d2h(input logic [7:0] st, input logic i);
    u_lds_dev_model.send(1'b1, 1'b0, {8'h00, st, 1'b0, i, 14'h34});
    repeat (3) u_lds_dev_model.send(1'b0, 1'b0, 32'h0);
    u_lds_dev_model.send(1'b0, 1'b1, 32'h0);
    wait_idle(0);
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e,
                        input string m);
    apb(1'b0, a, 32'h0);
    chk(q, e, m);
  endtask
  task automatic t_reset();
    rd_chk(lds_pkg::OFF_STATUS, 32'h0, "status reset");
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h0, "dma idle at reset");
    rd_chk(8'h28, 32'h0, "unmapped reads zero");
    chk({31'h0, err}, 32'h1, "unmapped error");
    chk({31'h0, host_intr}, 32'h0, "no interrupt at reset");
    $display("t_reset done");
  endtask
  task automatic t_cmd();
    issue(8'hec);
    d2h(8'h50, 1'b0);
    chk({31'h0, host_intr}, 32'h0, "interrupt without flag");
    rd_chk(lds_pkg::OFF_STATUS, 32'h50, "ending status");
    issue(8'hec);
    d2h(8'h51, 1'b1);
    chk({31'h0, host_intr}, 32'h1, "interrupt with flag");
    rd_chk(lds_pkg::OFF_STATUS, 32'h51, "ending status");
    repeat (2) @(posedge sys_clk);
    chk({31'h0, host_intr}, 32'h0, "status read clears interrupt");
    $display("t_cmd done");
  endtask
  task automatic t_dma_read();
    int k;
    apb(1'b1, lds_pkg::OFF_DMA_ADDR, 32'h100);
    apb(1'b1, lds_pkg::OFF_DMA_LEN, 32'h3);
    apb(1'b1, lds_pkg::OFF_DMA_CTRL, 32'h3);
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h1, "engine armed");
    rd_chk(lds_pkg::OFF_DMA_CTRL, 32'h3, "ctrl readback");
    issue(8'hc8);
    u_lds_dev_model.send(1'b1, 1'b0, 32'h46);
    for (k = 0; k < 3; k++)
      u_lds_dev_model.send(1'b0, k == 2, 32'h11110000 + k);
    wait_idle(0);
    for (k = 0; k < 3; k++)
      chk(mem_w[32'h100 + 4 * k], 32'h11110000 + k, "dma word");
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h0, "idle at zero count");
    rd_chk(lds_pkg::OFF_DMA_ADDR, 32'h10c, "pointer advanced");
    rd_chk(lds_pkg::OFF_DMA_LEN, 32'h0, "count spent");
    // A data frame reaching an idle engine must be dropped
    u_lds_dev_model.send(1'b1, 1'b0, 32'h46);
    u_lds_dev_model.send(1'b0, 1'b1, 32'hbad0bad0);
    wait_idle(0);
    chk(mem_w.num(), 32'h3, "write while idle");
    d2h(8'h50, 1'b1);
    rd_chk(lds_pkg::OFF_STATUS, 32'h50, "read ending status");
    $display("t_dma_read done");
  endtask
  // Ending status arrives with the engine still armed; software aborts
  task automatic t_early_end(input logic dir);
    apb(1'b1, lds_pkg::OFF_DMA_LEN, 32'h2);
    apb(1'b1, lds_pkg::OFF_DMA_CTRL, {30'h0, dir, 1'b1});
    issue(8'hc8);
    d2h(8'h51, 1'b1);
    rd_chk(lds_pkg::OFF_STATUS, 32'h51, "early ending status");
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h1, "still armed");
    apb(1'b1, lds_pkg::OFF_DMA_CTRL, 32'h0);
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h0, "aborted");
    $display("t_early_end done");
  endtask
  task automatic t_dma_write();
    int b;
    int k;
    slow <= 1'b1;
    apb(1'b1, lds_pkg::OFF_DMA_ADDR, 32'h200);
    apb(1'b1, lds_pkg::OFF_DMA_LEN, 32'h6);
    apb(1'b1, lds_pkg::OFF_DMA_CTRL, 32'h1);
    issue(8'hca);
    b = u_lds_dev_model.got_q.size();
    repeat (20) @(posedge sys_clk);
    chk(u_lds_dev_model.got_q.size(), b, "data before activate");
    u_lds_dev_model.send(1'b1, 1'b1, 32'h39);
    wait_idle(b + 5);
    chw(b, 2'b10, 32'h46);
    for (k = 0; k < 4; k++)
      chw(b + 1 + k, {1'b0, k == 3}, 32'hda7a0200 + 4 * k);
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h1, "rearmed");
    u_lds_dev_model.send(1'b1, 1'b1, 32'h39);
    wait_idle(b + 8);
    chw(b + 5, 2'b10, 32'h46);
    for (k = 0; k < 2; k++)
      chw(b + 6 + k, {1'b0, k == 1}, 32'hda7a0210 + 4 * k);
    rd_chk(lds_pkg::OFF_DMA_STAT, 32'h0, "idle at zero count");
    u_lds_dev_model.send(1'b1, 1'b1, 32'h39);
    wait_idle(0);
    repeat (20) @(posedge sys_clk);
    chk(u_lds_dev_model.got_q.size(), b + 8, "data past count");
    d2h(8'h50, 1'b1);
    slow <= 1'b0;
    $display("t_dma_write done");
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    t_reset();
    t_cmd();
    t_dma_read();
    t_early_end(1'b1);
    t_early_end(1'b0);
    t_dma_write();
    stop_test();
  end
endmodule
